//--- pcst_pkg.sv
// Package for the processor C-state and throttle block
package pcst_pkg;
    // Register offsets (byte addresses)
    localparam logic [7:0] PCST_ADDR_THROTTLE = 8'h10;
    localparam logic [7:0] PCST_ADDR_LEVEL2   = 8'h14;
    localparam logic [7:0] PCST_ADDR_LEVEL3   = 8'h15;
    localparam logic [7:0] PCST_ADDR_ARBCTL   = 8'h1C;
    localparam logic [7:0] PCST_ADDR_PMCTL    = 8'h20;
    // Field positions
    localparam int PCST_EN_BIT      = 4;
    localparam int PCST_RATIO_LSB   = 1;
    localparam int PCST_RATIO_W     = 3;
    localparam int PCST_ARBDIS_BIT  = 0;
    localparam int PCST_RELOAD_BIT  = 1;
    // Reset values
    localparam logic [31:0] PCST_THROTTLE_RST = 32'h00000000;
    localparam logic [7:0]  PCST_ARBCTL_RST   = 8'h00;
    localparam logic [7:0]  PCST_PMCTL_RST    = 8'h00;
    localparam logic [7:0]  PCST_LEVEL_READ   = 8'h00;
    // Throttle period in counter steps
    localparam int PCST_PERIOD_STEPS = 8;
    typedef enum logic [1:0] {
        PCST_C0 = 2'b00,
        PCST_C2 = 2'b01,
        PCST_C3 = 2'b10
    } pcst_cstate_t;
endpackage

//--- pcst_core.sv
// Processor C-state entry, throttle duty cycle and arbiter hold
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module pcst_core #(
    parameter int RATIO_W = pcst_pkg::PCST_RATIO_W
) (
    input  wire logic                  clock_in,
    input  wire logic                  rst_n_in,
    input  wire logic [7:0]            addr_in,
    input  wire logic [31:0]           wdata_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    output logic      [31:0]           rdata_out,
    input  wire logic                  thermal_throttle_in,
    input  wire logic                  pci_req_in,
    input  wire logic                  link_req_in,
    input  wire logic                  cstate_done_in,
    output logic                       stop_grant_out,
    output logic                       c2_entry_out,
    output logic                       c3_entry_out,
    output pcst_pkg::pcst_cstate_t     cstate_out,
    output logic                       pci_grant_block_out,
    output logic                       link_mem_block_out
);
    import pcst_pkg::*;

    // ******************************
    // Input synchronisers
    // ******************************
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end else begin
            sync_a <= {cstate_done_in, link_req_in, pci_req_in,
                       thermal_throttle_in};
            sync_b <= sync_a;
        end
    end
    logic thermal;
    logic bm_req;
    logic done;
    assign thermal = sync_b[0];
    assign bm_req  = sync_b[1] | sync_b[2];
    assign done    = sync_b[3];

    // ******************************
    // Registers
    // ******************************
    logic               throttle_enable;
    logic [RATIO_W-1:0] throttle_ratio;
    logic               arbiter_disable;
    logic               bus_master_reload;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            throttle_enable <= PCST_THROTTLE_RST[PCST_EN_BIT];
            throttle_ratio  <= PCST_THROTTLE_RST[PCST_RATIO_LSB +: RATIO_W];
        end else if (wr_in && addr_in == PCST_ADDR_THROTTLE) begin
            throttle_enable <= wdata_in[PCST_EN_BIT];
            throttle_ratio  <= wdata_in[PCST_RATIO_LSB +: RATIO_W];
        end
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arbiter_disable   <= PCST_ARBCTL_RST[PCST_ARBDIS_BIT];
            bus_master_reload <= PCST_PMCTL_RST[PCST_RELOAD_BIT];
        end else if (wr_in) begin
            if (addr_in == PCST_ADDR_ARBCTL)
                arbiter_disable <= wdata_in[PCST_ARBDIS_BIT];
            if (addr_in == PCST_ADDR_PMCTL)
                bus_master_reload <= wdata_in[PCST_RELOAD_BIT];
        end
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_out <= 32'h00000000;
        end else if (rd_in) begin
            unique case (addr_in)
                PCST_ADDR_THROTTLE: rdata_out <= {27'h0000000,
                    throttle_enable, throttle_ratio, 1'b0};
                PCST_ADDR_ARBCTL: rdata_out <= {31'h00000000,
                    arbiter_disable};
                PCST_ADDR_PMCTL: rdata_out <= {30'h00000000,
                    bus_master_reload, 1'b0};
                PCST_ADDR_LEVEL2,
                PCST_ADDR_LEVEL3: rdata_out <= {24'h000000,
                    PCST_LEVEL_READ};
                default: rdata_out <= 32'h00000000;
            endcase
        end else begin
            rdata_out <= 32'h00000000;
        end
    end

    // ******************************
    // Throttle duty cycle
    // ******************************
    // Free-running so ratio changes take effect without a restart
    logic [2:0] period_step;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in)
            period_step <= 3'h0;
        else
            period_step <= period_step + 3'h1;
    end
    // Ratio n holds stop grant for 8-n steps; 0 reserved, treated as off
    logic [3:0] grant_steps;
    assign grant_steps = (throttle_ratio == 3'h0) ? 4'h0 :
        4'(PCST_PERIOD_STEPS) - {1'b0, throttle_ratio};
    logic next_stop_grant;
    assign next_stop_grant = throttle_enable && !thermal
        && ({1'b0, period_step} < grant_steps);
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in)
            stop_grant_out <= 1'b0;
        else
            stop_grant_out <= next_stop_grant;
    end

    // ******************************
    // C-state entry
    // ******************************
    logic lvl2_read;
    logic lvl3_read;
    assign lvl2_read = rd_in && addr_in == PCST_ADDR_LEVEL2;
    assign lvl3_read = rd_in && addr_in == PCST_ADDR_LEVEL3;
    pcst_cstate_t cstate;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cstate <= PCST_C0;
        end else begin
            unique case (cstate)
                PCST_C0: begin
                    if (lvl3_read)
                        cstate <= PCST_C3;
                    else if (lvl2_read)
                        cstate <= PCST_C2;
                end
                PCST_C2: begin
                    if (done)
                        cstate <= PCST_C0;
                end
                PCST_C3: begin
                    if (done || (bus_master_reload && bm_req))
                        cstate <= PCST_C0;
                end
                default: cstate <= PCST_C0;
            endcase
        end
    end
    assign cstate_out = cstate;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            c2_entry_out <= 1'b0;
            c3_entry_out <= 1'b0;
        end else begin
            c2_entry_out <= lvl2_read && cstate == PCST_C0 && !lvl3_read;
            c3_entry_out <= lvl3_read && cstate == PCST_C0;
        end
    end

    // ******************************
    // Arbiter hold
    // ******************************
    assign pci_grant_block_out = arbiter_disable;
    assign link_mem_block_out  = arbiter_disable;

    // ******************************
    // Assertions
    // ******************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    AST_THR_OFF: assert property (!throttle_enable |=> !stop_grant_out)
        else $error("stop grant while throttle off");
    AST_THERMAL: assert property (thermal |=> !stop_grant_out)
        else $error("stop grant during thermal throttle");
    AST_RATIO7: assert property (throttle_enable && !thermal
        && throttle_ratio == 3'h7 && period_step == 3'h0
        |=> stop_grant_out)
        else $error("ratio 7 step 0 lacks stop grant");
    AST_RATIO_LIM: assert property (period_step >= 3'h7
        |=> !stop_grant_out)
        else $error("stop grant on last step");
    AST_RDBACK: assert property (wr_in && addr_in == PCST_ADDR_THROTTLE
        ##1 rd_in && addr_in == PCST_ADDR_THROTTLE
        |=> rdata_out[4:0] == {$past(wdata_in[4:1], 2), 1'b0})
        else $error("throttle control readback wrong");
    AST_C2: assert property (lvl2_read && !lvl3_read && cstate == PCST_C0
        |=> cstate == PCST_C2 && c2_entry_out)
        else $error("level two read did not enter C2");
    AST_C3: assert property (lvl3_read && cstate == PCST_C0
        |=> cstate == PCST_C3 && c3_entry_out)
        else $error("level three read did not enter C3");
    AST_LVL_ZERO: assert property (lvl2_read || lvl3_read
        |=> rdata_out == 32'h00000000)
        else $error("level register read nonzero");
    AST_ARB: assert property (arbiter_disable
        |-> pci_grant_block_out && link_mem_block_out)
        else $error("arbiter disable not applied");
    AST_LINK: assert property (!arbiter_disable |-> !link_mem_block_out)
        else $error("link blocked while enabled");
    AST_RELOAD: assert property (cstate == PCST_C3 && bus_master_reload
        && bm_req |=> cstate == PCST_C0)
        else $error("bus master did not wake C3");
    // First edge after reset has no valid history
    AST_STEP: assert property ($past(rst_n_in)
        |-> period_step == $past(period_step) + 3'h1)
        else $error("period counter stalled");

    // Entry pulses and state holds; wake is seen two cycles late
    AST_C2_HOLD: assert property (cstate == PCST_C2 && !done
        |=> cstate == PCST_C2)
        else $error("C2 left without wake");
    AST_C2_EXIT: assert property (cstate == PCST_C2 && done
        |=> cstate == PCST_C0)
        else $error("C2 did not return to C0");
    AST_C3_HOLD: assert property (cstate == PCST_C3 && !done
        && !(bus_master_reload && bm_req) |=> cstate == PCST_C3)
        else $error("C3 left without wake");
    AST_C3_EXIT: assert property (cstate == PCST_C3 && done
        |=> cstate == PCST_C0)
        else $error("C3 did not return to C0");
    AST_NO_RELOAD: assert property (cstate == PCST_C3 && !done
        && !bus_master_reload && bm_req |=> cstate == PCST_C3)
        else $error("request woke C3 with reload clear");
    AST_C2_PULSE: assert property (c2_entry_out |=> !c2_entry_out)
        else $error("C2 entry pulse too long");
    AST_C3_PULSE: assert property (c3_entry_out |=> !c3_entry_out)
        else $error("C3 entry pulse too long");
    AST_REENTRY: assert property (cstate != PCST_C0
        |=> !c2_entry_out && !c3_entry_out)
        else $error("entry pulse outside C0");
    AST_ONE_ENTRY: assert property (!(c2_entry_out && c3_entry_out))
        else $error("both entry pulses at once");

    // Duty cycle end points and the ratio 4 midpoint
    AST_RATIO1: assert property (throttle_enable && !thermal
        && throttle_ratio == 3'h1 && period_step == 3'h6
        |=> stop_grant_out)
        else $error("ratio 1 step 6 lacks stop grant");
    AST_RATIO0: assert property (throttle_ratio == 3'h0
        |=> !stop_grant_out)
        else $error("stop grant with reserved ratio");
    AST_RATIO7_OFF: assert property (throttle_ratio == 3'h7
        && period_step != 3'h0 |=> !stop_grant_out)
        else $error("ratio 7 stop grant past step 0");
    AST_HALF: assert property (throttle_enable && !thermal
        && throttle_ratio == 3'h4
        |=> stop_grant_out == !$past(period_step[2]))
        else $error("ratio 4 duty cycle wrong");

    // Register bus
    AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 32'h00000000)
        else $error("read data outside its cycle");
    AST_THR_RSVD: assert property (rd_in
        && addr_in == PCST_ADDR_THROTTLE
        |=> rdata_out[31:5] == 27'h0000000 && !rdata_out[0])
        else $error("throttle reserved bits not zero");
    AST_EN_WR: assert property (wr_in && addr_in == PCST_ADDR_THROTTLE
        |=> throttle_enable == $past(wdata_in[PCST_EN_BIT]))
        else $error("throttle enable write lost");
    AST_THR_HOLD: assert property (!(wr_in
        && addr_in == PCST_ADDR_THROTTLE)
        |=> $stable(throttle_enable) && $stable(throttle_ratio))
        else $error("throttle control changed without write");
    AST_ARB_WR: assert property (wr_in && addr_in == PCST_ADDR_ARBCTL
        |=> arbiter_disable == $past(wdata_in[PCST_ARBDIS_BIT]))
        else $error("arbiter disable write lost");
    AST_ARB_RB: assert property (rd_in && addr_in == PCST_ADDR_ARBCTL
        |=> rdata_out == {31'h00000000, $past(arbiter_disable)})
        else $error("arbiter control readback wrong");
    AST_RELOAD_WR: assert property (wr_in && addr_in == PCST_ADDR_PMCTL
        |=> bus_master_reload == $past(wdata_in[PCST_RELOAD_BIT]))
        else $error("bus master reload write lost");
    AST_GRANT_OFF: assert property (!arbiter_disable
        |-> !pci_grant_block_out)
        else $error("grants blocked while enabled");

    COV_C2: cover property (cstate == PCST_C0 ##1 cstate == PCST_C2);
    COV_C2_EXIT: cover property (cstate == PCST_C2 ##1 cstate == PCST_C0);
    COV_ARB: cover property ($rose(arbiter_disable));
    COV_C3_WAKE: cover property (cstate == PCST_C3 && bm_req
        ##1 cstate == PCST_C0);
    COV_THROTTLE: cover property (!stop_grant_out ##1 stop_grant_out);
endmodule

//--- pcst_host_model.sv
// Host processor wake handshake and bus master request model
`timescale 1ns/1ps
// ****************************
// Host and bus master model
// ****************************
module pcst_host_model (
    input  wire logic       clock_in,
    input  wire logic       entry_in,
    input  wire logic       wake_en_in,
    input  wire logic [3:0] delay_in,
    input  wire logic [1:0] kick_in,
    output logic            done_out,
    output logic            pci_req_out,
    output logic            link_req_out
);
    int cnt;
    initial begin
        cnt = 0;
        done_out = 1'b0;
        pci_req_out = 1'b0;
        link_req_out = 1'b0;
    end
    // Wake held four cycles so the two-stage sync cannot miss it
    always @(posedge clock_in) begin
        if (entry_in && wake_en_in) cnt <= delay_in + 4;
        else if (cnt > 0) cnt <= cnt - 1;
        done_out <= (cnt >= 1 && cnt <= 4);
        pci_req_out <= kick_in[0];
        link_req_out <= kick_in[1];
    end
endmodule

//--- tb_top.sv
// Self-checking bench for the C-state and throttle block
`timescale 1ns/1ps
module tb_top;
    import pcst_pkg::*;
    logic clock_in = 0, rst_n_in = 0, wr = 0, rd = 0, thermal = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic c2, c3, sg, pblk, lblk, done, preq, lreq, e2, e3, wake = 0;
    logic [3:0] dly = 4'h0;
    logic [1:0] kick = 2'h0;
    pcst_cstate_t cs;
    int err_count = 0, checks = 0, seed = 32'he8113b9b, r, n;
    always #25 clock_in = ~clock_in;
    pcst_core uut (.clock_in(clock_in), .rst_n_in(rst_n_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .thermal_throttle_in(thermal), .pci_req_in(preq),
        .link_req_in(lreq), .cstate_done_in(done), .stop_grant_out(sg),
        .c2_entry_out(c2), .c3_entry_out(c3), .cstate_out(cs),
        .pci_grant_block_out(pblk), .link_mem_block_out(lblk));
    pcst_host_model host (.clock_in(clock_in), .entry_in(c2 | c3),
        .wake_en_in(wake), .delay_in(dly), .kick_in(kick), .done_out(done),
        .pci_req_out(preq), .link_req_out(lreq));
    // ****************************
    // Bus and compare tasks
    // ****************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clock_in); wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clock_in); addr <= a; rd <= 1'b1;
        @(posedge clock_in); rd <= 1'b0;
        #1 q = rdata; e2 = c2; e3 = c3;
    endtask
    task count_sg;
        n = 0;
        repeat (8) begin
            @(posedge clock_in); #1 n += sg;
        end
    endtask
    task wait_c0;
        for (int i = 0; i < 40 && cs !== PCST_C0; i++) begin
            @(posedge clock_in); #1;
        end
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #(50 * 6000); err_count++; results;
    end
    // ****************************
    // Scenarios
    // ****************************
    initial begin
        repeat (16) @(posedge clock_in);
        rst_n_in <= 1'b1;
        rd_reg(PCST_ADDR_THROTTLE); chk(q, 32'h0);
        rd_reg(PCST_ADDR_ARBCTL); chk(q, 32'h0);
        rd_reg(8'h30); chk(q, 32'h0);
        for (r = 0; r < 8; r++) begin
            wr_reg(PCST_ADDR_THROTTLE, {$random(seed)} & 32'hFFFFFFE1 | 32'h10 | r << 1);
            rd_reg(PCST_ADDR_THROTTLE); chk(q, 32'h10 | r << 1);
            repeat (4) @(posedge clock_in);
            count_sg; chk(n, r == 0 ? 0 : 8 - r);
        end
        wr_reg(PCST_ADDR_THROTTLE, 32'h08);
        repeat (4) @(posedge clock_in);
        count_sg; chk(n, 0);
        wr_reg(PCST_ADDR_THROTTLE, 32'h18); thermal <= 1'b1;
        repeat (5) @(posedge clock_in);
        count_sg; chk(n, 0);
        thermal <= 1'b0;
        repeat (5) @(posedge clock_in);
        count_sg; chk(n, 4);
        wake <= 1'b1; dly <= 4'($random(seed));
        rd_reg(PCST_ADDR_LEVEL2); chk(q, 32'h0);
        chk({e2, 2'(cs)}, 3'h5);
        rd_reg(PCST_ADDR_LEVEL3); chk(e3, 0);
        wait_c0; chk(2'(cs), 2'h0);
        wake <= 1'b0;
        wr_reg(PCST_ADDR_PMCTL, 32'h2);
        rd_reg(PCST_ADDR_LEVEL3); chk({e3, 2'(cs)}, 3'h6);
        repeat (20) @(posedge clock_in);
        chk(2'(cs), 2'h2);
        kick <= 2'h2;
        wait_c0; chk(2'(cs), 2'h0);
        kick <= 2'h0; wake <= 1'b1; dly <= 4'hF;
        wr_reg(PCST_ADDR_PMCTL, 32'h0);
        rd_reg(PCST_ADDR_LEVEL3); kick <= 2'h1;
        repeat (8) @(posedge clock_in);
        chk(2'(cs), 2'h2);
        kick <= 2'h0;
        wait_c0; chk(2'(cs), 2'h0);
        wr_reg(PCST_ADDR_ARBCTL, 32'h1 | {$random(seed)});
        #1 chk({pblk, lblk}, 2'h3);
        wr_reg(PCST_ADDR_ARBCTL, 32'h0);
        #1 chk({pblk, lblk}, 2'h0);
        results;
    end
endmodule
